/* core/dcc_regs.svh */
/*
  Register offsets, field positions and reset values of the dual comparator control block.
  Assumes inclusion from core design files only.
*/
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

`define DCC_ADDR_W 12
`define DCC_OFF_CONTROL 12'h000
`define DCC_OFF_IRQ_STATUS 12'h004
`define DCC_OFF_IRQ_MASK 12'h008
`define DCC_OFF_PIN_DIR 12'h00c
`define DCC_OFF_INPUT_SEL 12'h010
`define DCC_CTRL_RESET 8'h00
`define DCC_MASK_RESET 8'h00
`define DCC_DIR_RESET 8'hff
`define DCC_DIR_ONE_PIN 6
`define DCC_DIR_TWO_PIN 7
`define DCC_BIT_TWO_RESULT 7
`define DCC_BIT_ONE_RESULT 6
`define DCC_BIT_TWO_INV 5
`define DCC_BIT_ONE_INV 4
`define DCC_BIT_SWITCH 3
`define DCC_MODE_HI 2
`define DCC_MODE_LO 0
`define DCC_WR_MASK 8'h3f
`define DCC_IRQ_CHANGE 0
`define DCC_IRQ_W 1

`endif

/* core/dcc_pkg.sv */
/*
  Types shared by the dual comparator control design.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dcc_pkg;
  // Configuration select values
  typedef enum logic [2:0] {
    DCC_MODE_RESET = 3'h0,
    DCC_MODE_ONE_IND = 3'h1,
    DCC_MODE_TWO_IND = 3'h2,
    DCC_MODE_TWO_OUT = 3'h3,
    DCC_MODE_TWO_COMMON = 3'h4,
    DCC_MODE_COMMON_OUT = 3'h5,
    DCC_MODE_FOUR_MUX = 3'h6,
    DCC_MODE_OFF = 3'h7
  } dcc_mode_e;
endpackage

/* core/dcc_sync.sv */
/*
  Two flip-flop synchroniser for a vector of independent levels.
  Assumes each bit is a level from outside the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_sync
#(
  parameter int WIDTH = 2
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_one <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule
`default_nettype wire

/* core/dcc_top.sv */
/*
  Control and status logic of a dual analog comparator unit behind an APB slave.
  Assumes the analog comparators, pins and voltage reference sit outside; raw
  comparator levels arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcc_regs.svh"
module dcc_top
  import dcc_pkg::*;
#(
  parameter int PIN_COUNT = 6
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DCC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_one_raw,
  input wire logic cmp_two_raw,
  output logic cmp_enable,
  output logic cmp_hold_reset,
  output logic [PIN_COUNT-1:0] pin_analog,
  output logic [PIN_COUNT-1:0] port_a_direction,
  output logic [2:0] cmp_one_plus_sel,
  output logic [2:0] cmp_one_minus_sel,
  output logic [2:0] cmp_two_plus_sel,
  output logic [2:0] cmp_two_minus_sel,
  output logic cmp_one_plus_vref,
  output logic cmp_two_plus_vref,
  output logic cmp_one_pin_out,
  output logic cmp_two_pin_out,
  output logic cmp_one_pin_oe,
  output logic cmp_two_pin_oe,
  output logic irq
);
  logic [7:0] comparator_control;
  logic [7:0] next_control;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] pin_dir;
  logic [1:0] raw_sync;
  logic [1:0] result_now;
  logic [1:0] last_read;
  logic [1:0] next_last_read;
  logic mismatch;
  logic access;
  logic wr_en;
  logic rd_en;
  logic low_lane;
  logic addr_ok;
  logic ctrl_hit;
  logic [7:0] ctrl_view;
  logic [7:0] next_status;
  logic [31:0] next_prdata;
  dcc_mode_e mode;
  dcc_mode_e next_mode;

  // Level synchroniser for both raw comparator outputs
  dcc_sync #(
    .WIDTH(2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({cmp_two_raw, cmp_one_raw}),
    .sync_out(raw_sync)
  );

  // APB access decode; one wait-free access phase
  assign access = psel && penable;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;
  assign low_lane = pstrb[0];
  assign pready = 1'b1;
  assign addr_ok = (paddr == `DCC_OFF_CONTROL) || (paddr == `DCC_OFF_IRQ_STATUS)
    || (paddr == `DCC_OFF_IRQ_MASK) || (paddr == `DCC_OFF_PIN_DIR)
    || (paddr == `DCC_OFF_INPUT_SEL);
  assign pslverr = access && !addr_ok;
  assign ctrl_hit = access && (paddr == `DCC_OFF_CONTROL);
  assign mode = dcc_mode_e'(comparator_control[`DCC_MODE_HI:`DCC_MODE_LO]);
  assign next_mode = dcc_mode_e'(next_control[`DCC_MODE_HI:`DCC_MODE_LO]);

  // Results after optional inversion, held low while the comparators are inactive
  always_comb
  begin
    result_now = raw_sync ^ {comparator_control[`DCC_BIT_TWO_INV],
      comparator_control[`DCC_BIT_ONE_INV]};
    if (mode == DCC_MODE_RESET || mode == DCC_MODE_OFF)
    begin
      result_now = 2'h0;
    end
  end

  // Control register view with live result bits
  always_comb
  begin
    ctrl_view = comparator_control;
    ctrl_view[`DCC_BIT_TWO_RESULT] = result_now[1];
    ctrl_view[`DCC_BIT_ONE_RESULT] = result_now[0];
  end

  // Next control value; result bits are read only and never stored
  always_comb
  begin
    next_control = comparator_control;
    if (wr_en && low_lane && paddr == `DCC_OFF_CONTROL)
    begin
      next_control = pwdata[7:0] & `DCC_WR_MASK;
    end
  end

  // Writable control bits; pin enables below follow the same next value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      comparator_control <= `DCC_CTRL_RESET;
    end
    else
    begin
      comparator_control <= next_control;
    end
  end

  // Mask and pin direction registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask <= `DCC_MASK_RESET;
      pin_dir <= `DCC_DIR_RESET;
    end
    else if (wr_en && low_lane)
    begin
      if (paddr == `DCC_OFF_IRQ_MASK)
      begin
        irq_mask <= pwdata[7:0];
      end
      if (paddr == `DCC_OFF_PIN_DIR)
      begin
        pin_dir <= pwdata[7:0];
      end
    end
  end

  // Last-read copy of the results; any control access refreshes it
  always_comb
  begin
    next_last_read = last_read;
    if (ctrl_hit)
    begin
      next_last_read = result_now;
      if (!pwrite)
      begin
        // A read settles on the bits it returned, so a change since setup still flags
        next_last_read = prdata[`DCC_BIT_TWO_RESULT:`DCC_BIT_ONE_RESULT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_read <= 2'h0;
    end
    else
    begin
      last_read <= next_last_read;
    end
  end

  assign mismatch = (result_now != last_read) && !ctrl_hit;

  // Sticky change flag: set by mismatch or software write of one, read clears,
  // and a set in the clearing cycle wins
  always_comb
  begin
    next_status = irq_status;
    if (rd_en && paddr == `DCC_OFF_IRQ_STATUS)
    begin
      next_status = irq_status & ~prdata[7:0]; // Only bits the read returned, none lost
    end
    if (wr_en && low_lane && paddr == `DCC_OFF_IRQ_STATUS && pwdata[`DCC_IRQ_CHANGE])
    begin
      next_status[`DCC_IRQ_CHANGE] = 1'b1;
    end
    if (mismatch)
    begin
      next_status[`DCC_IRQ_CHANGE] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= 8'h00;
    end
    else
    begin
      irq_status <= next_status;
    end
  end

  // Level interrupt output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(next_status & irq_mask);
    end
  end

  // Read data mux
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `DCC_OFF_CONTROL: next_prdata[7:0] = ctrl_view;
      `DCC_OFF_IRQ_STATUS: next_prdata[7:0] = irq_status;
      `DCC_OFF_IRQ_MASK: next_prdata[7:0] = irq_mask;
      `DCC_OFF_PIN_DIR: next_prdata[7:0] = pin_dir;
      `DCC_OFF_INPUT_SEL: next_prdata[7:0] = {cmp_two_plus_vref, cmp_one_plus_vref,
        cmp_two_minus_sel[1:0], cmp_one_minus_sel[1:0], cmp_enable, cmp_hold_reset};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Read data taken into a register during setup so it stands in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= next_prdata;
    end
  end

  // Input routing per configuration; pins 0..3 are C1-, C2-, C1+, C2+,
  // the switched negative inputs reuse pins 2 and 3; pins 4 and 5 are never selected
  always_comb
  begin
    cmp_one_minus_sel = 3'h0;
    cmp_two_minus_sel = 3'h1;
    cmp_one_plus_sel = 3'h2;
    cmp_two_plus_sel = 3'h3;
    cmp_one_plus_vref = 1'b0;
    cmp_two_plus_vref = 1'b0;
    cmp_enable = 1'b1;
    cmp_hold_reset = 1'b0;
    pin_analog = {PIN_COUNT{1'b1}};
    case (mode)
      DCC_MODE_RESET:
      begin
        cmp_enable = 1'b0;
        cmp_hold_reset = 1'b1;
      end
      DCC_MODE_ONE_IND:
      begin
        pin_analog = PIN_COUNT'(6'h0f);
      end
      DCC_MODE_TWO_IND, DCC_MODE_TWO_OUT:
      begin
        pin_analog = PIN_COUNT'(6'h0f);
      end
      DCC_MODE_TWO_COMMON, DCC_MODE_COMMON_OUT:
      begin
        cmp_two_plus_sel = 3'h2;
        pin_analog = PIN_COUNT'(6'h07);
      end
      DCC_MODE_FOUR_MUX:
      begin
        cmp_one_plus_vref = 1'b1;
        cmp_two_plus_vref = 1'b1;
        if (comparator_control[`DCC_BIT_SWITCH])
        begin
          cmp_one_minus_sel = 3'h2;
          cmp_two_minus_sel = 3'h3;
        end
        pin_analog = PIN_COUNT'(6'h0f);
      end
      DCC_MODE_OFF:
      begin
        cmp_enable = 1'b0;
        pin_analog = {PIN_COUNT{1'b0}};
      end
      default:
      begin
        cmp_enable = 1'b0;
      end
    endcase
  end

  assign port_a_direction = pin_dir[PIN_COUNT-1:0];

  // Result pins in output modes; direction bits gate the drivers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_one_pin_out <= 1'b0;
      cmp_two_pin_out <= 1'b0;
      cmp_one_pin_oe <= 1'b0;
      cmp_two_pin_oe <= 1'b0;
    end
    else
    begin
      cmp_one_pin_out <= result_now[0];
      cmp_two_pin_out <= result_now[1];
      // Enables track the mode being written, so no pin drives after a switch-off
      cmp_one_pin_oe <= (next_mode == DCC_MODE_TWO_OUT || next_mode == DCC_MODE_COMMON_OUT)
        && !pin_dir[`DCC_DIR_ONE_PIN];
      cmp_two_pin_oe <= (next_mode == DCC_MODE_TWO_OUT || next_mode == DCC_MODE_COMMON_OUT)
        && !pin_dir[`DCC_DIR_TWO_PIN];
    end
  end
endmodule
`default_nettype wire

/* verification/dcc_top_assertions.sv */
/* Port checks for the dual comparator control block.
   Assumes binding into dcc_top, one clock pclk, presetn active low. */
`timescale 1ns/1ps
`default_nettype none
module dcc_chk
#(
  parameter int PIN_COUNT = 6
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic cmp_one_raw,
  input wire logic cmp_two_raw,
  input wire logic cmp_enable,
  input wire logic cmp_hold_reset,
  input wire logic [PIN_COUNT-1:0] pin_analog,
  input wire logic [PIN_COUNT-1:0] port_a_direction,
  input wire logic cmp_one_plus_vref,
  input wire logic cmp_two_plus_vref,
  input wire logic cmp_one_pin_out,
  input wire logic cmp_two_pin_out,
  input wire logic cmp_one_pin_oe,
  input wire logic cmp_two_pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wc;
  // Control write completing at this edge
  assign wc = psel && penable && pwrite && pstrb[0] && paddr == 12'h000;
  sequence s_calm_one; $stable(cmp_one_raw)[*4]; endsequence
  sequence s_calm_two; $stable(cmp_two_raw)[*4]; endsequence
  chk_hold_reset: assert property (
    wc && pwdata[2:0] == 3'h0 |=> cmp_hold_reset && !cmp_enable && &pin_analog)
    else $error("hold mode wrong");
  chk_off_mode: assert property (
    wc && pwdata[2:0] == 3'h7 |=> !cmp_enable && !cmp_hold_reset)
    else $error("off mode wrong");
  chk_vref_mode: assert property (
    wc && pwdata[2:0] == 3'h6 |=> cmp_one_plus_vref && cmp_two_plus_vref)
    else $error("reference not routed");
  chk_pin_enable: assert property (
    cmp_one_pin_oe || cmp_two_pin_oe |-> cmp_enable)
    else $error("pin driven while off");
  chk_dir_write: assert property (
    psel && penable && pwrite && pstrb[0] && paddr == 12'h00c
    |=> port_a_direction == $past(pwdata[5:0]))
    else $error("direction lost");
  chk_sync_delay: assert property (
    $changed(cmp_one_raw) && !$past(psel) |-> $stable(cmp_one_pin_out))
    else $error("result not synchronised");
  // Pin two cycles after a quiet write: raw level at the write edge with the new sense
  chk_inv_two: assert property (
    s_calm_two ##0 wc && pwdata[2:0] == 3'h3
    |=> ##1 cmp_two_pin_out == ($past(cmp_two_raw, 2) ^ $past(pwdata[5], 2)))
    else $error("two sense");
  chk_inv_one: assert property (
    s_calm_one ##0 wc && pwdata[2:0] == 3'h3
    |=> ##1 cmp_one_pin_out == ($past(cmp_one_raw, 2) ^ $past(pwdata[4], 2)))
    else $error("one sense");
endmodule
bind dcc_top dcc_chk #(.PIN_COUNT(PIN_COUNT)) i_dcc_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .cmp_one_raw, .cmp_two_raw, .cmp_enable, .cmp_hold_reset,
  .pin_analog, .port_a_direction, .cmp_one_plus_vref, .cmp_two_plus_vref, .cmp_one_pin_out,
  .cmp_two_pin_out, .cmp_one_pin_oe, .cmp_two_pin_oe);
`default_nettype wire

/* verification/dcc_analog_model.sv */
/* Analog side: two comparators fed by the bench's input levels.
   Assumes levels say whether each positive input is above its negative one. */
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model
(
  input wire logic cmp_enable,
  input wire logic one_above,
  input wire logic two_above,
  output logic cmp_one_raw,
  output logic cmp_two_raw
);
  // Outputs lag the inputs, unrelated to pclk; powered down reads low
  assign #1 cmp_one_raw = cmp_enable & one_above;
  assign #1 cmp_two_raw = cmp_enable & two_above;
endmodule
`default_nettype wire

/* verification/dual_comparator_control_tb.sv */
/* Self-checking bench for dcc_top over APB.
   Assumes the analog model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, one_above = 0, two_above = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, serr, cmp_one_raw, cmp_two_raw, cmp_enable, cmp_hold_reset, irq;
  logic cmp_one_plus_vref, cmp_one_pin_out, cmp_two_pin_out;
  logic [2:0] cmp_one_minus_sel, cmp_two_minus_sel;
  logic [5:0] pin_analog, port_a_direction;
  int err_total = 0, n_tests = 0;
  // Clock at 200 MHz
  initial forever #2.5 pclk = ~pclk;
  dcc_top i_dcc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .cmp_one_raw, .cmp_two_raw, .cmp_enable,
    .cmp_hold_reset, .pin_analog, .port_a_direction, .cmp_one_plus_sel(),
    .cmp_one_minus_sel, .cmp_two_plus_sel(), .cmp_two_minus_sel, .cmp_one_plus_vref,
    .cmp_two_plus_vref(), .cmp_one_pin_out, .cmp_two_pin_out, .cmp_one_pin_oe(),
    .cmp_two_pin_oe(), .irq);
  dcc_analog_model i_dcc_analog_model (.cmp_enable, .one_above, .two_above, .cmp_one_raw,
    .cmp_two_raw);
  task give_verdict;
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_total++;
      give_verdict();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task t_reset;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk({cmp_hold_reset, cmp_enable, pin_analog}, {2'b10, 6'h3f});
    apb(1'b0, 12'h020, 32'h0);
    chk(serr, 1'b1);
    apb(1'b1, 12'h00c, 32'h15);
    chk(port_a_direction, 6'h15);
  endtask
  task t_modes;
    apb(1'b1, 12'h008, 32'h0);
    for (int m = 0; m < 8; m++)
    begin
      apb(1'b1, 12'h000, m);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[2:0], m);
      chk(cmp_enable, m != 0 && m != 7);
      chk(cmp_one_plus_vref, m == 6);
      chk(cmp_hold_reset, m == 0);
    end
    // Switch bit in mode 110 moves each negative input onto its positive-input pin
    apb(1'b1, 12'h000, 32'h06);
    chk({cmp_one_minus_sel, cmp_two_minus_sel}, {3'h0, 3'h1});
    apb(1'b1, 12'h000, 32'h0e);
    chk({cmp_one_minus_sel, cmp_two_minus_sel}, {3'h2, 3'h3});
  endtask
  // Every level and inversion pair, with ones written to the read-only bits
  task t_result;
    for (int k = 0; k < 16; k++)
    begin
      one_above <= k[0];
      two_above <= k[1];
      repeat (6) @(posedge pclk);
      apb(1'b1, 12'h000, {2'b11, k[3:2], 4'h3});
      repeat (6) @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[7:6], {k[1] ^ k[3], k[0] ^ k[2]});
      chk({cmp_two_pin_out, cmp_one_pin_out}, {k[1] ^ k[3], k[0] ^ k[2]});
    end
  endtask
  task t_irq;
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(irq, 1'b0);
    one_above <= ~one_above;
    repeat (6) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    repeat (2) @(posedge pclk);
    chk({rd[0], irq}, 2'b11);
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, 12'h004, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, 12'h008, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
  endtask
  // Reset in mid-run returns every register to its reset value
  task t_midreset;
    apb(1'b1, 12'h000, 32'h3e);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk({cmp_hold_reset, cmp_enable, irq, port_a_direction}, {3'b100, 6'h3f});
  endtask
  // Reset for 8 cycles, then the scenarios in turn
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_modes();
    t_result();
    t_irq();
    t_midreset();
    give_verdict();
  end
endmodule
`default_nettype wire
